// ===== hdl/pin_sync.sv
// Purpose: Two-flop synchroniser for the data bus inputs.
// Assumes: Single clock clk_sys, synchronous active-low reset.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module pin_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [`DATA_WIDTH-1:0] async_in,
	output logic [`DATA_WIDTH-1:0] sync_out
);
	logic [`DATA_WIDTH-1:0] stage1;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1 <= 8'h00;
			sync_out <= 8'h00;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// ===== hdl/sram_host.sv
// Purpose: Host controller driving a 32K x 8 asynchronous static memory.
// Assumes: clk_sys 50 MHz; memory of the slow grade or faster on the pins.
// Notes: One access at a time; req_ready high only in the idle state.
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module sram_host (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [`ADDR_WIDTH-1:0] req_address,
	input wire logic [`DATA_WIDTH-1:0] req_wdata,
	output logic rsp_valid,
	output logic [`DATA_WIDTH-1:0] rsp_rdata,
	output logic [`ADDR_WIDTH-1:0] word_address,
	output logic chip_select_n,
	output logic drive_en_n,
	output logic write_strobe_n,
	input wire logic [`DATA_WIDTH-1:0] shared_data_bus_in,
	output logic [`DATA_WIDTH-1:0] shared_data_bus_out,
	output logic shared_data_bus_oe
);
	localparam logic [`CNT_WIDTH-1:0] READ_WAIT = `CNT_WIDTH'(`READ_WAIT_CYCLES);
	localparam logic [`CNT_WIDTH-1:0] WRITE_WAIT = `CNT_WIDTH'(`WRITE_WAIT_CYCLES);
	localparam logic [`CNT_WIDTH-1:0] FLOAT_WAIT = `CNT_WIDTH'(`FLOAT_WAIT_CYCLES);
	localparam logic [`CNT_WIDTH-1:0] READ_CYCLE = `CNT_WIDTH'(`READ_CYCLE_CYCLES);
	localparam logic [`CNT_WIDTH-1:0] WRITE_CYCLE = `CNT_WIDTH'(`WRITE_CYCLE_CYCLES);

	sram_host_pkg::seq_state_type state;
	logic [`CNT_WIDTH-1:0] count;
	logic [`DATA_WIDTH-1:0] bus_sync;
	logic accept;
	logic [`CNT_WIDTH-1:0] addr_age;

	pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(shared_data_bus_in),
		.sync_out(bus_sync)
	);

	assign req_ready = (state == sram_host_pkg::st_idle);
	assign accept = req_valid && req_ready;

	// Sequencer: read, write and float states each hold for a whole count before moving on.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= sram_host_pkg::st_idle;
			count <= 3'h0;
		end else begin
			case (state)
				sram_host_pkg::st_idle: begin
					count <= 3'h0;
					if (accept) begin
						state <= req_write ? sram_host_pkg::st_write : sram_host_pkg::st_read;
					end
				end
				sram_host_pkg::st_read: begin
					// Address is held stable for the whole wait.
					if (count == READ_WAIT - 3'h1) begin
						state <= sram_host_pkg::st_float;
						count <= 3'h0;
					end else begin
						count <= count + 3'h1;
					end
				end
				sram_host_pkg::st_write: begin
					// Select, strobe, address and data all held the full wait.
					if (count == WRITE_WAIT - 3'h1) begin
						state <= sram_host_pkg::st_write_end;
						count <= 3'h0;
					end else begin
						count <= count + 3'h1;
					end
				end
				sram_host_pkg::st_write_end: begin
					// One cycle of data and address hold after the strobe rises.
					state <= sram_host_pkg::st_idle;
				end
				sram_host_pkg::st_float: begin
					// Wait for device drivers to release before the next write.
					if (count == FLOAT_WAIT - 3'h1) begin
						state <= sram_host_pkg::st_idle;
						count <= 3'h0;
					end else begin
						count <= count + 3'h1;
					end
				end
				default: begin
					state <= sram_host_pkg::st_idle;
					count <= 3'h0;
				end
			endcase
		end
	end

	// Address and data latch on the accept edge, the same edge on which select falls.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			word_address <= 15'h0000;
			shared_data_bus_out <= 8'h00;
		end else if (accept) begin
			word_address <= req_address;
			shared_data_bus_out <= req_wdata;
		end
	end

	// Cycles since the address last moved; it saturates so long idle spells stay legal.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_age <= 3'h7;
		end else if (accept) begin
			addr_age <= 3'h0;
		end else if (addr_age != 3'h7) begin
			addr_age <= addr_age + 3'h1;
		end
	end

	// Strobes come from flip-flops so no glitch reaches the memory.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			chip_select_n <= 1'b1;
			drive_en_n <= 1'b1;
			write_strobe_n <= 1'b1;
			shared_data_bus_oe <= 1'b0;
		end else begin
			chip_select_n <= !((accept) ||
				(state == sram_host_pkg::st_read && count != READ_WAIT - 3'h1) ||
				(state == sram_host_pkg::st_write && count != WRITE_WAIT - 3'h1));
			// Output enable only for reads, so the bus never fights the host.
			drive_en_n <= !((accept && !req_write) ||
				(state == sram_host_pkg::st_read && count != READ_WAIT - 3'h1));
			// Select and strobe rise together, ending the write on both.
			write_strobe_n <= !((accept && req_write) ||
				(state == sram_host_pkg::st_write && count != WRITE_WAIT - 3'h1));
			// Host drives data through the write and its hold cycle.
			shared_data_bus_oe <= (accept && req_write) || (state == sram_host_pkg::st_write);
		end
	end

	// Read data sampled at the end of the access window.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= (state == sram_host_pkg::st_read) && (count == READ_WAIT - 3'h1);
			if ((state == sram_host_pkg::st_read) && (count == READ_WAIT - 3'h1)) begin
				rsp_rdata <= bus_sync;
			end
		end
	end

	sequence write_start;
		$fell(write_strobe_n) && !chip_select_n;
	endsequence
	sequence write_hold;
		!write_strobe_n [*3];
	endsequence

	a_write_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		write_start |-> write_hold) else $error("write strobe too short");
	a_write_both_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!write_strobe_n |-> !chip_select_n) else $error("strobe low without select");
	a_strobe_select_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(write_strobe_n) |-> $rose(chip_select_n)) else $error("write end not joint");
	a_no_bus_fight: assert property (@(posedge clk_sys) disable iff (!rst_n)
		shared_data_bus_oe |-> drive_en_n) else $error("host drives while memory enabled");
	a_data_hold_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(write_strobe_n) |-> shared_data_bus_oe) else $error("data not held");
	a_addr_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!chip_select_n && !$past(chip_select_n) |-> $stable(word_address))
		else $error("address moved during access");
	a_read_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(drive_en_n) |-> !drive_en_n [*5]) else $error("read too short");
	a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(drive_en_n) |-> ##6 rsp_valid) else $error("read answer late");
	a_addr_before_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(chip_select_n) |-> word_address == $past(req_address) ##1 $stable(word_address))
		else $error("address late");
	a_float_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(drive_en_n) |-> !shared_data_bus_oe [*2]) else $error("no float gap");

	sequence select_held;
		!chip_select_n [*3];
	endsequence
	sequence write_released;
		write_strobe_n && chip_select_n && shared_data_bus_oe;
	endsequence
	sequence float_hold;
		!req_ready ##1 !req_ready ##1 req_ready;
	endsequence

	// A write lasts exactly the select wait, then both strobes release with data still driven.
	a_write_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
		write_start |-> select_held ##1 write_released) else $error("write length wrong");
	a_addr_write_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(write_strobe_n) |-> $stable(word_address)) else $error("address moved at end");
	a_wdata_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!write_strobe_n && !$past(write_strobe_n) |->
		$stable(shared_data_bus_out) && shared_data_bus_oe) else $error("write data moved");
	a_data_setup: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(write_strobe_n) |-> shared_data_bus_oe) else $error("write data not driven");

	// Read and write minima are checked together, since the next kind is not known yet.
	a_cycle_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		accept |-> addr_age >= READ_CYCLE - 3'h1 && addr_age >= WRITE_CYCLE - 3'h1)
		else $error("cycle too short");
	a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rsp_valid |=> !rsp_valid) else $error("answer pulse too long");
	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!rsp_valid |-> $stable(rsp_rdata)) else $error("read data moved");
	a_read_no_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!drive_en_n |-> write_strobe_n && !shared_data_bus_oe) else $error("read not clean");

	// Idle keeps select high so the memory drops back to standby between accesses.
	a_idle_released: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req_ready |-> chip_select_n && write_strobe_n && drive_en_n && !shared_data_bus_oe)
		else $error("pins active in idle");
	a_float_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(drive_en_n) |-> float_hold) else $error("float wait wrong");
endmodule

// ===== hdl/sram_host_cfg.svh
// Purpose: Constants for the host controller of a 32K x 8 asynchronous static memory.
// Assumes: clk_sys at 50 MHz (20 ns period); slow speed grade timing is used.
// Notes: Times are in ns; cycle counts derive from them.
// Notes on behaviour
// - Write happens only while select and write strobe are both low.
// - Host presents a valid address no later than select falling for reads.
// - Host holds each read address stable at least 55 or 70 ns.
// - Host makes each write cycle last at least 55 or 70 ns.
// - Host holds select low at least 50 or 60 ns before write end.
// - Host holds address valid at least 50 or 60 ns before write end.
// - Host drives write data 25 or 30 ns before write end, holds it past.
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
`define CLK_PERIOD_NS 20
`define ADDR_WIDTH 15
`define DATA_WIDTH 8
`define READ_CYCLE_MIN_NS 70
`define SELECT_TO_DATA_MAX_NS 70
`define DRIVE_EN_TO_DATA_MAX_NS 35
`define FLOAT_MAX_NS 25
`define WRITE_CYCLE_MIN_NS 70
`define SELECT_TO_WRITE_END_NS 60
`define ADDRESS_TO_WRITE_END_NS 60
`define DATA_SETUP_TO_WRITE_END_NS 30
`define NS_TO_CYCLES_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Sampling waits two cycles beyond the access limit for the input synchroniser.
`define READ_WAIT_CYCLES (`NS_TO_CYCLES_UP(`SELECT_TO_DATA_MAX_NS) + 2)
`define WRITE_WAIT_CYCLES `NS_TO_CYCLES_UP(`SELECT_TO_WRITE_END_NS)
`define READ_CYCLE_CYCLES `NS_TO_CYCLES_UP(`READ_CYCLE_MIN_NS)
`define WRITE_CYCLE_CYCLES `NS_TO_CYCLES_UP(`WRITE_CYCLE_MIN_NS)
`define FLOAT_WAIT_CYCLES `NS_TO_CYCLES_UP(`FLOAT_MAX_NS)
`define CNT_WIDTH 3
`endif

// ===== hdl/sram_host_pkg.sv
// Purpose: Types shared by the memory host controller.
// Assumes: Constants come from sram_host_cfg.svh.
// Notes: Holds only the sequencer state type.
package sram_host_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_read,
		st_write,
		st_write_end,
		st_float
	} seq_state_type;
endpackage

// ===== test/sram_dev_model.sv
// Purpose: Behavioural model of the 32K x 8 asynchronous static memory at the pins.
// Assumes: Host pins as driven by sram_host; ACCESS_NS sets how slowly it answers.
// Notes: A floating bus shows the inverse of its last level, so stale data never passes.
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module sram_dev_model #(
	parameter int ACCESS_NS = 60
) (
	input wire logic clk_sys,
	input wire logic [`ADDR_WIDTH-1:0] word_address,
	input wire logic chip_select_n,
	input wire logic drive_en_n,
	input wire logic write_strobe_n,
	input wire logic [`DATA_WIDTH-1:0] host_data,
	input wire logic host_oe,
	output logic [`DATA_WIDTH-1:0] bus_level
);
	logic [`DATA_WIDTH-1:0] mem [0:(1<<`ADDR_WIDTH)-1];
	logic dev_on = 1'b0;
	logic armed = 1'b0;
	logic [`DATA_WIDTH-1:0] last = 8'h00;
	initial begin
		for (int i = 0; i < (1<<`ADDR_WIDTH); i++) mem[i] = 8'h00;
	end
	// Turning on waits far past the low-Z minimum; turning off is at once, inside every limit.
	always @(chip_select_n or drive_en_n or write_strobe_n) begin
		if (!chip_select_n && !drive_en_n && write_strobe_n) begin
			dev_on <= #(ACCESS_NS) 1'b1;
		end else begin
			dev_on = 1'b0;
		end
	end
	always @(negedge (chip_select_n | write_strobe_n)) armed = 1'b1;
	always @(posedge (chip_select_n | write_strobe_n)) begin
		if (armed) begin
			mem[word_address] = host_data;
			armed = 1'b0;
		end
	end
	assign bus_level = host_oe ? host_data : (dev_on ? mem[word_address] : ~last);
	always @(posedge clk_sys) last <= bus_level;
endmodule

// ===== test/sram_host_tb.sv
// Purpose: Self-checking bench for sram_host against a memory model.
// Assumes: 50 MHz clock; read answer 6 cycles after the taking edge.
// Notes: A reference array holds every byte written; unwritten bytes read as zero.
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module sram_host_tb;
	logic clk_sys, rst_n, req_valid, req_ready, req_write, rsp_valid;
	logic [`ADDR_WIDTH-1:0] req_address, word_address;
	logic [`DATA_WIDTH-1:0] req_wdata, rsp_rdata, bus_in, bus_out;
	logic chip_select_n, drive_en_n, write_strobe_n, bus_oe;
	logic [`DATA_WIDTH-1:0] ref_mem [int];
	int miscompares = 0;
	int total_checks = 0;
	sram_host sram_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_address(req_address),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.word_address(word_address), .chip_select_n(chip_select_n),
		.drive_en_n(drive_en_n), .write_strobe_n(write_strobe_n),
		.shared_data_bus_in(bus_in), .shared_data_bus_out(bus_out),
		.shared_data_bus_oe(bus_oe));
	sram_dev_model #(.ACCESS_NS(`SELECT_TO_DATA_MAX_NS)) sram_dev_model_i (.clk_sys(clk_sys),
		.word_address(word_address), .chip_select_n(chip_select_n),
		.drive_en_n(drive_en_n), .write_strobe_n(write_strobe_n),
		.host_data(bus_out), .host_oe(bus_oe), .bus_level(bus_in));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic conclude;
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t byte got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_flag(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t condition false", $time);
		end
	endtask
	task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_address <= a;
		req_wdata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 30);
		req_valid <= 1'b0;
		if (n >= 30) begin
			miscompares++;
			conclude();
		end
		if (w) begin
			ref_mem[a] = d;
			@(posedge clk_sys);
		end else begin
			repeat (6) @(posedge clk_sys);
			#1;
			check_flag(rsp_valid === 1'b1);
			check_byte(rsp_rdata, ref_mem.exists(a) ? ref_mem[a] : 8'h00);
			@(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys) begin
		if (rst_n) begin
			check_flag(!(bus_oe === 1'b1 && drive_en_n === 1'b0));
			check_flag(!(write_strobe_n === 1'b0 && chip_select_n !== 1'b0));
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end
	initial begin
		logic [14:0] a;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_address = 15'h0000;
		req_wdata = 8'h00;
		void'($urandom(32));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		xfer(1'b1, 15'h0000, 8'h5A);
		xfer(1'b1, 15'h7FFF, 8'hA5);
		xfer(1'b0, 15'h0000, 8'h00);
		xfer(1'b0, 15'h7FFF, 8'h00);
		xfer(1'b1, 15'h7FFF, 8'h3C);
		xfer(1'b0, 15'h7FFF, 8'h00);
		repeat (60) begin
			a = 15'($urandom);
			xfer(1'b1, a, 8'($urandom));
			xfer(1'b0, a, 8'h00);
			xfer(1'b0, 15'($urandom), 8'h00);
		end
		conclude();
	end
endmodule
